// ### verilog/ext_irq_ctrl.v
// External request and pin-change interrupt controller
// ============================================================
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module ext_irq_ctrl
#(
	parameter NEXT = 4
)
(
	input  wire            i_mclk,
	input  wire            i_srst,
	input  wire [NEXT-2:0] i_ext_request_pins,
	input  wire [7:0]      i_port_c,
	input  wire [7:0]      i_pcin_lo,
	input  wire [7:0]      i_pcin_hi,
	input  wire [7:0]      i_pin_change_mask_0,
	input  wire [7:0]      i_pin_change_mask_1,
	input  wire [7:0]      i_pin_change_mask_2,
	input  wire [7:0]      i_pin_change_mask_3,
	input  wire [7:0]      i_ext_request_sense_ctrl,
	input  wire [NEXT-1:0] i_ext_enable,
	input  wire [NEXT-1:0] i_ext_clear,
	input  wire [2:0]      i_pc_clear,
	input  wire            i_sleep,
	input  wire [2:0]      i_sleep_mode,
	input  wire            i_startup_done,
	input  wire            i_internal_irq,
	output reg  [NEXT-1:0] o_ext_flag,
	output reg  [NEXT-1:0] o_ext_irq,
	output reg  [2:0]      o_pc_flag,
	output reg  [2:0]      o_pc_irq,
	output reg             o_wake,
	output reg  [NEXT-1:0] o_clamp_override,
	output reg             o_input_clamp,
	output reg             o_io_clk_run
);
	// ============================================================
	// Input synchronisers
	wire [NEXT-1:0] raw_ext;
	wire [23:0]     raw_pc;
	wire [NEXT-1:0] ext_s;
	wire [23:0]     pc_s;
	wire [NEXT-1:0] ext_in;
	wire [23:0]     pc_in;

	// Port C bit 0 doubles as request 3
	assign raw_ext = {i_port_c[`PORTC_EXT3_BIT], i_ext_request_pins};
	assign raw_pc  = {i_pcin_hi, i_port_c, i_pcin_lo};

	sync2 #(.WIDTH(NEXT)) u_sync_ext
	(
		.i_mclk (i_mclk),
		.i_srst (i_srst),
		.i_d    (raw_ext),
		.o_q    (ext_s)
	);

	sync2 #(.WIDTH(24)) u_sync_pc
	(
		.i_mclk (i_mclk),
		.i_srst (i_srst),
		.i_d    (raw_pc),
		.o_q    (pc_s)
	);

	// ============================================================
	// Sleep state and input clamp
	reg  clamp_mode;
	reg  io_run;
	reg  was_clamped;
	wire resume;

	always @*
	begin
		case (i_sleep_mode)
			`SLEEP_PDOWN: clamp_mode = 1'b1;
			`SLEEP_PSAVE: clamp_mode = 1'b1;
			`SLEEP_STDBY: clamp_mode = 1'b1;
			default:      clamp_mode = 1'b0;
		endcase
		io_run = !i_sleep || (i_sleep_mode == `SLEEP_IDLE);
	end

	// Clamped pins read low unless their request is enabled
	assign ext_in = (i_sleep && clamp_mode) ? (ext_s & i_ext_enable) : ext_s;
	assign pc_in  = pc_s;

	assign resume = was_clamped && !(i_sleep && clamp_mode);

	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			was_clamped      <= 1'b0;
			o_input_clamp    <= 1'b0;
			o_clamp_override <= {NEXT{1'b0}};
			o_io_clk_run     <= 1'b1;
		end
		else
		begin
			was_clamped      <= i_sleep && clamp_mode;
			o_input_clamp    <= i_sleep && clamp_mode;
			o_clamp_override <= i_ext_enable;
			o_io_clk_run     <= io_run;
		end
	end

	// ============================================================
	// External request pins, dedicated and Port C bit 0
	reg  [NEXT-1:0] ext_last;
	reg  [NEXT-1:0] ext_hit;
	reg  [NEXT-1:0] level_hit;
	reg  [1:0]      sense;
	integer         k;

	always @*
	begin
		ext_hit   = {NEXT{1'b0}};
		level_hit = {NEXT{1'b0}};
		sense     = 2'h0;
		for (k = 0; k < NEXT; k = k + 1)
		begin
			sense = i_ext_request_sense_ctrl[2*k +: 2];
			case (sense)
				`SENSE_LOW:
					level_hit[k] = !ext_in[k];
				`SENSE_ANY:
					ext_hit[k] = io_run && (ext_in[k] != ext_last[k]);
				`SENSE_FALL:
					ext_hit[k] = io_run && ext_last[k] && !ext_in[k];
				`SENSE_RISE:
					ext_hit[k] = io_run && !ext_last[k] && ext_in[k];
				default:
					ext_hit[k] = 1'b0;
			endcase
			// Clamp released on a high pin flags any disabled edge-sensed request, falling sense included
			if (resume && !i_ext_enable[k] && sense != `SENSE_LOW && ext_s[k])
				ext_hit[k] = 1'b1;
		end
	end

	// Edge history advances while the I/O clock runs and in the cycle the clamp is released
	always @(posedge i_mclk)
	begin
		if (i_srst)
			ext_last <= {NEXT{1'b0}};
		else if (io_run || resume)
			ext_last <= ext_in;
	end

	// ============================================================
	// Pin-change groups
	wire [2:0] pc_pend;
	wire [2:0] pc_wake;

	pin_change_group #(.WIDTH(8)) u_pc0
	(
		.i_mclk    (i_mclk),
		.i_srst    (i_srst),
		.i_pins    (pc_in[`PC_G0_HI:`PC_G0_LO]),
		.i_mask    (i_pin_change_mask_0),
		.i_clear   (i_pc_clear[0]),
		.o_pending (pc_pend[0]),
		.o_wake    (pc_wake[0])
	);

	pin_change_group #(.WIDTH(7)) u_pc1
	(
		.i_mclk    (i_mclk),
		.i_srst    (i_srst),
		.i_pins    (pc_in[`PC_G1_HI:`PC_G1_LO]),
		.i_mask    (i_pin_change_mask_1[6:0]),
		.i_clear   (i_pc_clear[1]),
		.o_pending (pc_pend[1]),
		.o_wake    (pc_wake[1])
	);

	pin_change_group #(.WIDTH(8)) u_pc2
	(
		.i_mclk    (i_mclk),
		.i_srst    (i_srst),
		.i_pins    (pc_in[`PC_G2_HI:`PC_G2_LO]),
		.i_mask    (i_pin_change_mask_2),
		.i_clear   (i_pc_clear[2]),
		.o_pending (pc_pend[2]),
		.o_wake    (pc_wake[2])
	);

	// ============================================================
	// Pending flags, requests and wake-up
	reg [NEXT-1:0] next_ext_flag;
	reg            next_wake;
	integer        j;

	always @*
	begin
		// Edge events latch; level sense follows the pin while low
		next_ext_flag = (o_ext_flag & ~i_ext_clear) | ext_hit | level_hit;
		for (j = 0; j < NEXT; j = j + 1)
			if (i_ext_request_sense_ctrl[2*j +: 2] == `SENSE_LOW && !ext_hit[j])
				next_ext_flag[j] = level_hit[j];
		next_wake = 1'b0;
		if (i_sleep)
		begin
			if (i_sleep_mode == `SLEEP_IDLE)
				next_wake = |(ext_hit & i_ext_enable) | |(pc_pend & i_pin_change_mask_3[2:0])
					| i_internal_irq | |(level_hit & i_ext_enable);
			else
				next_wake = |(level_hit & i_ext_enable) | |pc_wake;
		end
	end

	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_ext_flag <= {NEXT{1'b0}};
			o_ext_irq  <= {NEXT{1'b0}};
			o_pc_flag  <= 3'h0;
			o_pc_irq   <= 3'h0;
			o_wake     <= 1'b0;
		end
		else
		begin
			o_ext_flag <= next_ext_flag;
			// A level gone before start-up ends gives no request
			o_ext_irq  <= next_ext_flag & i_ext_enable & {NEXT{i_startup_done}};
			o_pc_flag  <= pc_pend;
			o_pc_irq   <= pc_pend & i_pin_change_mask_3[2:0];
			o_wake     <= next_wake;
		end
	end
endmodule

// ### include/ext_irq_map.vh
// Constants for the external and pin-change request block
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH
`define SENSE_LOW      2'h0
`define SENSE_ANY      2'h1
`define SENSE_FALL     2'h2
`define SENSE_RISE     2'h3
`define SLEEP_IDLE     3'h0
`define SLEEP_ADCNR    3'h1
`define SLEEP_PDOWN    3'h2
`define SLEEP_PSAVE    3'h3
`define SLEEP_STDBY    3'h6
`define PC_G0_LO       0
`define PC_G0_HI       7
`define PC_G1_LO       8
`define PC_G1_HI       14
`define PC_G2_LO       16
`define PC_G2_HI       23
`define PORTC_PC_BASE  8
`define PORTC_EXT3_BIT 0
`endif

// ### verilog/sync2.v
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module sync2
#(
	parameter WIDTH = 1
)
(
	input  wire             i_mclk,
	input  wire             i_srst,
	input  wire [WIDTH-1:0] i_d,
	output reg  [WIDTH-1:0] o_q
);
	reg [WIDTH-1:0] meta;

	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			meta <= {WIDTH{1'b0}};
			o_q  <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule

// ### verilog/pin_change_group.v
// One pin-change group: masked toggle detect and sticky pending flag
`timescale 1ns/1ps
module pin_change_group
#(
	parameter WIDTH = 8
)
(
	input  wire             i_mclk,
	input  wire             i_srst,
	input  wire [WIDTH-1:0] i_pins,
	input  wire [WIDTH-1:0] i_mask,
	input  wire             i_clear,
	output reg              o_pending,
	output wire             o_wake
);
	reg [WIDTH-1:0] last;
	wire            hit;

	assign hit = |((i_pins ^ last) & i_mask);
	assign o_wake = hit;

	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			last      <= {WIDTH{1'b0}};
			o_pending <= 1'b0;
		end
		else
		begin
			last <= i_pins;
			if (hit)
				o_pending <= 1'b1;
			else if (i_clear)
				o_pending <= 1'b0;
		end
	end
endmodule

// ### sim/ext_irq_ctrl_sva.sv
// Port assertions for the request controller
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module ext_irq_ctrl_sva
#(
	parameter NEXT = 4
)
(
	input wire            i_mclk,
	input wire            i_srst,
	input wire [NEXT-2:0] i_ext_request_pins,
	input wire [7:0]      i_pin_change_mask_2,
	input wire [7:0]      i_pin_change_mask_3,
	input wire [7:0]      i_ext_request_sense_ctrl,
	input wire [NEXT-1:0] i_ext_enable,
	input wire            i_sleep,
	input wire [2:0]      i_sleep_mode,
	input wire [NEXT-1:0] o_ext_flag,
	input wire [NEXT-1:0] o_ext_irq,
	input wire [2:0]      o_pc_flag,
	input wire [2:0]      o_pc_irq,
	input wire [NEXT-1:0] o_clamp_override,
	input wire            o_input_clamp,
	input wire            o_io_clk_run
);
	// ==========
	// Checks
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	rise_flag_a: assert property (
		$rose(i_ext_request_pins[0]) && !i_sleep
		&& i_ext_request_sense_ctrl[1:0] == `SENSE_RISE |-> ##3 o_ext_flag[0])
		else $error("rise not flagged");
	low_level_a: assert property (
		(i_ext_request_sense_ctrl[3:2] == `SENSE_LOW && !i_ext_request_pins[1])[*3]
		|=> o_ext_flag[1]) else $error("low level not flagged");
	irq_enable_a: assert property (
		o_ext_irq[0] |-> $past(i_ext_enable[0])) else $error("irq without enable");
	sleep_clamp_a: assert property (
		i_sleep && i_sleep_mode == `SLEEP_PDOWN |=> o_input_clamp)
		else $error("no clamp in power-down");
	io_clock_a: assert property (
		i_sleep && i_sleep_mode != `SLEEP_IDLE |=> !o_io_clk_run)
		else $error("io clock runs in sleep");
	clamp_override_a: assert property (
		i_ext_enable[2] |=> o_clamp_override[2]) else $error("override missing");
	masked_group_a: assert property (
		$rose(o_pc_flag[2])
		|-> ($past(i_pin_change_mask_2) | $past(i_pin_change_mask_2, 2)) != 8'h00)
		else $error("masked change flagged");
	group_irq_a: assert property (
		o_pc_irq[1] |-> $past(i_pin_change_mask_3[1])) else $error("group irq not enabled");
endmodule
bind ext_irq_ctrl ext_irq_ctrl_sva #(.NEXT(NEXT)) u_sva (.i_mclk, .i_srst, .i_ext_request_pins,
	.i_pin_change_mask_2, .i_pin_change_mask_3, .i_ext_request_sense_ctrl, .i_ext_enable,
	.i_sleep, .i_sleep_mode, .o_ext_flag, .o_ext_irq, .o_pc_flag, .o_pc_irq,
	.o_clamp_override, .o_input_clamp, .o_io_clk_run);

// ### sim/board_pins.sv
// Board-side model driving request and pin-change pins
`timescale 1ns/1ps
module board_pins
(
	input  wire [26:0] i_level,
	output wire [2:0]  o_req,
	output wire [7:0]  o_port_c,
	output wire [15:0] o_pcin
);
	// ==========
	// Levels hold until the bench moves them
	assign o_req = i_level[2:0];
	assign o_port_c = i_level[10:3];
	assign o_pcin = i_level[26:11];
endmodule

// ### sim/test_ext_irq_ctrl.sv
// Self-checking bench for the request controller
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module test_ext_irq_ctrl;
	reg        i_mclk = 1'b0;
	reg        i_srst = 1'b1;
	reg [26:0] lvl = 27'h0000002;
	reg [7:0]  m0 = 8'h00;
	reg [7:0]  m1 = 8'h00;
	reg [7:0]  m2 = 8'h00;
	reg [3:0]  en = 4'h0;
	reg [3:0]  clr = 4'h0;
	reg [2:0]  pcc = 3'h0;
	reg        slp = 1'b0;
	wire [2:0] req;
	wire [7:0] pc;
	wire [15:0] pcin;
	wire [3:0] ef;
	wire [2:0] pf;
	reg [6:0]  q[$];
	integer    miscompares = 0;
	integer    check_count = 0;
	integer    cyc = 0;
	integer    b;
	integer    k;
	// ==========
	// Design and board
	board_pins i_board (.i_level(lvl), .o_req(req), .o_port_c(pc), .o_pcin(pcin));
	ext_irq_ctrl i_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ext_request_pins(req),
		.i_port_c(pc), .i_pcin_lo(pcin[7:0]), .i_pcin_hi(pcin[15:8]),
		.i_pin_change_mask_0(m0), .i_pin_change_mask_1(m1), .i_pin_change_mask_2(m2),
		.i_pin_change_mask_3(8'h07), .i_ext_request_sense_ctrl(8'h63), .i_ext_enable(en),
		.i_ext_clear(clr), .i_pc_clear(pcc), .i_sleep(slp), .i_sleep_mode(`SLEEP_PDOWN),
		.i_startup_done(1'b1), .i_internal_irq(1'b0), .o_ext_flag(ef), .o_ext_irq(),
		.o_pc_flag(pf), .o_pc_irq(), .o_wake(), .o_clamp_override(), .o_input_clamp(),
		.o_io_clk_run());
	initial
		forever #2.5 i_mclk = ~i_mclk;
	// ==========
	// Checking
	task check(input [6:0] seen, input [6:0] want);
	begin
		check_count = check_count + 1;
		if (seen !== want)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %0t flags %h want %h", $time, seen, want);
		end
	end
	endtask
	task give_verdict;
	begin
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	always @(negedge i_mclk)
		if (q.size() > 0)
			check({ef, pf}, q.pop_front());
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 1000)
		begin
			miscompares = miscompares + 1;
			give_verdict;
		end
	end
	// ==========
	// Stimulus
	task look(input integer n, input [6:0] e);
	begin
		repeat (n) @(posedge i_mclk);
		q.push_back(e);
	end
	endtask
	task wipe;
	begin
		clr <= 4'hf;
		pcc <= 3'h7;
		@(posedge i_mclk);
		clr <= 4'h0;
		pcc <= 3'h0;
		look(3, 7'h00);
	end
	endtask
	initial
	begin
		b = $urandom(23536);
		look(6, 7'h00);
		i_srst <= 1'b0;
		en <= 4'hf;
		look(4, 7'h00);
		wipe;
		lvl[0] <= 1'b1;
		look(4, 7'h08);
		lvl[1] <= 1'b0;
		look(6, 7'h18);
		lvl[1] <= 1'b1;
		look(4, 7'h08);
		wipe;
		m1 <= 8'h01;
		lvl[3] <= 1'b1;
		look(6, 7'h42);
		wipe;
		for (k = 0; k < 4; k = k + 1)
		begin
			b = $urandom % 8;
			m0 <= 8'h01 << b;
			lvl[18:11] <= lvl[18:11] ^ (8'h01 << ((b + 1) % 8));
			look(6, 7'h00);
			lvl[18:11] <= lvl[18:11] ^ (8'h01 << b);
			look(6, 7'h01);
			wipe;
		end
		m2 <= 8'h80;
		lvl[26] <= 1'b1;
		look(6, 7'h04);
		wipe;
		slp <= 1'b1;
		lvl[0] <= 1'b0;
		look(4, 7'h00);
		lvl[0] <= 1'b1;
		look(4, 7'h00);
		slp <= 1'b0;
		en <= 4'hb;
		lvl[2] <= 1'b1;
		look(4, 7'h00);
		wipe;
		slp <= 1'b1;
		look(4, 7'h00);
		slp <= 1'b0;
		look(5, 7'h20);
		look(2, 7'h20);
		give_verdict;
	end
endmodule
